// ==== design/pts_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pts_defines.svh"

module pts_sequencer
	import pts_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [15:0] trig_in,
	output logic [31:0] trigger_line,
	output logic [3:0] seq_irq,
	output logic [15:0] adc_channel_select_reg
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [15:0] queue_reg [16];
	logic [15:0] limit_reg [`PTS_LIM_COUNT];
	logic [15:0] hold_value_reg;
	logic [15:0] adjust_value_reg;
	logic [31:0] broadcast_enable_reg;
	logic [15:0] loop_count_a_reg;
	logic [15:0] loop_count_b_reg;
	logic [4:0] queue_pointer_reg;
	logic [4:0] pend_ptr_reg;
	logic [15:0] delay_cnt_reg;
	logic [15:0] timer_cnt_reg;
	logic [3:0] wait_sel_reg;
	pts_wait_t wait_kind_reg;
	pts_state_t state_reg;
	logic module_enable_bit_reg;
	logic run_bit_reg;
	logic software_trigger_bit_reg;
	logic swt_prev_reg;
	logic step_delay_timer_reg;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic wr_pend_reg;
	logic rd_wait_reg;
	logic [7:0] addr_reg;
	logic [31:0] rd_mux;
	logic accept;
	logic locked;
	logic wr_go;

	assign accept = hsel && htrans[1] && hready;
	assign hreadyout = !rd_wait_reg;
	assign hresp = 1'b0;
	assign locked = module_enable_bit_reg && run_bit_reg;
	assign wr_go = wr_pend_reg;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= accept && hwrite;
			rd_wait_reg <= accept && !hwrite;
			if (accept) begin
				addr_reg <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_wait_reg) begin
			hrdata <= rd_mux;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_reg[7:6] == `PTS_QUEUE_TAG) begin
			rd_mux = {16'h0000, queue_reg[addr_reg[5:2]]};
		end else if (addr_reg == `PTS_OFF_CTRL) begin
			rd_mux = {24'h00_0000, state_reg, step_delay_timer_reg, software_trigger_bit_reg,
				run_bit_reg, module_enable_bit_reg};
		end else if (addr_reg == `PTS_OFF_BTE) begin
			rd_mux = broadcast_enable_reg;
		end else if (addr_reg == `PTS_OFF_HOLD) begin
			rd_mux = {16'h0000, hold_value_reg};
		end else if (addr_reg == `PTS_OFF_ADJ) begin
			rd_mux = {16'h0000, adjust_value_reg};
		end else if (addr_reg >= `PTS_OFF_LIM0 && addr_reg <= `PTS_OFF_LIM5 && addr_reg[1:0] == 2'h0) begin
			rd_mux = {16'h0000, limit_reg[3'(addr_reg[5:2] - 4'h4)]};
		end else if (addr_reg == `PTS_OFF_QPTR) begin
			rd_mux = {27'h000_0000, queue_pointer_reg};
		end else if (addr_reg == `PTS_OFF_ADCSEL) begin
			rd_mux = {16'h0000, adc_channel_select_reg};
		end else if (addr_reg == `PTS_OFF_CNTA) begin
			rd_mux = {16'h0000, loop_count_a_reg};
		end else if (addr_reg == `PTS_OFF_CNTB) begin
			rd_mux = {16'h0000, loop_count_b_reg};
		end
	end

	// ----------------------------------------
	// input synchronisers and edge detect
	// ----------------------------------------
	logic [15:0] sync1_reg;
	logic [15:0] sync2_reg;
	logic [15:0] sync3_reg;
	logic [15:0] level_reg;
	logic [15:0] level_prev_reg;
	logic [15:0] rise;
	logic [15:0] fall;

	generate
		for (genvar i = 0; i < 16; i++) begin : g_sync
			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
					sync3_reg[i] <= 1'b0;
					level_reg[i] <= 1'b0;
					level_prev_reg[i] <= 1'b0;
				end else begin
					sync1_reg[i] <= trig_in[i];
					sync2_reg[i] <= sync1_reg[i];
					sync3_reg[i] <= sync2_reg[i];
					if (sync2_reg[i] == sync3_reg[i]) begin
						level_reg[i] <= sync3_reg[i];
					end
					level_prev_reg[i] <= level_reg[i];
				end
			end
			assign rise[i] = level_reg[i] && !level_prev_reg[i];
			assign fall[i] = !level_reg[i] && level_prev_reg[i];
		end
	endgenerate

	// ----------------------------------------
	// step decode
	// ----------------------------------------
	logic [7:0] cur_byte;
	logic [3:0] cmd;
	logic [3:0] opt;
	logic [4:0] five;
	logic exec;
	logic is_wait;
	logic [4:0] ptr_inc;
	logic [4:0] exec_ptr;
	logic cond_met;
	logic finish;
	logic [4:0] finish_ptr;
	logic [15:0] timer_lim;
	logic swt_rise;
	logic lim_we;
	logic [2:0] lim_idx;
	logic [15:0] lim_val;

	// queue word holds two step bytes, even step low
	assign cur_byte = queue_pointer_reg[0] ? queue_reg[queue_pointer_reg[4:1]][15:8]
		: queue_reg[queue_pointer_reg[4:1]][7:0];
	assign cmd = cur_byte[7:4];
	assign opt = cur_byte[3:0];
	assign five = cur_byte[4:0];
	assign exec = state_reg == PTS_EXEC;
	assign ptr_inc = queue_pointer_reg + 5'h01;
	assign swt_rise = software_trigger_bit_reg && !swt_prev_reg;
	assign timer_lim = wait_sel_reg[0] ? limit_reg[`PTS_LIM_TMR_B] : limit_reg[`PTS_LIM_TMR_A];
	// add or copy into the limit bank
	assign lim_idx = opt[2:0];
	assign lim_we = exec && cmd == `PTS_CMD_ADD && lim_idx <= `PTS_LIM_LITERAL;
	assign lim_val = opt[3] ? hold_value_reg : limit_reg[lim_idx] + adjust_value_reg;

	always_comb begin
		is_wait = 1'b0;
		if (cmd == `PTS_CMD_RISE || cmd == `PTS_CMD_FALL) begin
			is_wait = 1'b1;
		end else if (cmd == `PTS_CMD_CTRL) begin
			is_wait = opt == `PTS_OPT_TMR_A || opt == `PTS_OPT_TMR_B || opt == `PTS_OPT_SWT;
		end
	end

	always_comb begin
		exec_ptr = ptr_inc;
		if (cmd[3:1] == `PTS_GRP_JMP) begin
			exec_ptr = five;
		end else if (cmd[3:1] == `PTS_GRP_LOOPA && loop_count_a_reg != limit_reg[`PTS_LIM_LOOP_A]) begin
			exec_ptr = five;
		end else if (cmd[3:1] == `PTS_GRP_LOOPB && loop_count_b_reg != limit_reg[`PTS_LIM_LOOP_B]) begin
			exec_ptr = five;
		end
	end

	always_comb begin
		case (wait_kind_reg)
			PTS_W_RISE: cond_met = rise[wait_sel_reg];
			PTS_W_FALL: cond_met = fall[wait_sel_reg];
			PTS_W_TIMER: cond_met = timer_cnt_reg == timer_lim;
			default: cond_met = swt_rise;
		endcase
	end

	assign finish = (exec && !is_wait) || (state_reg == PTS_WAIT && cond_met);
	assign finish_ptr = exec ? exec_ptr : pend_ptr_reg;

	// ----------------------------------------
	// sequencer state machine
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= PTS_IDLE;
			queue_pointer_reg <= 5'h00;
			pend_ptr_reg <= 5'h00;
			delay_cnt_reg <= 16'h0000;
			timer_cnt_reg <= 16'h0000;
			wait_sel_reg <= 4'h0;
			wait_kind_reg <= PTS_W_RISE;
		end else if (!locked) begin
			state_reg <= PTS_IDLE;
			if (wr_go && addr_reg == `PTS_OFF_QPTR) begin
				queue_pointer_reg <= hwdata[4:0];
			end
		end else begin
			timer_cnt_reg <= timer_cnt_reg + 16'h0001;
			case (state_reg)
				PTS_IDLE: begin
					state_reg <= PTS_EXEC;
				end
				PTS_EXEC: begin
					wait_sel_reg <= opt;
					timer_cnt_reg <= 16'h0000;
					if (is_wait) begin
						state_reg <= PTS_WAIT;
						pend_ptr_reg <= ptr_inc;
						if (cmd == `PTS_CMD_RISE) begin
							wait_kind_reg <= PTS_W_RISE;
						end else if (cmd == `PTS_CMD_FALL) begin
							wait_kind_reg <= PTS_W_FALL;
						end else if (opt == `PTS_OPT_SWT) begin
							wait_kind_reg <= PTS_W_SWT;
						end else begin
							wait_kind_reg <= PTS_W_TIMER;
						end
					end
				end
				PTS_DELAY: begin
					delay_cnt_reg <= delay_cnt_reg - 16'h0001;
					if (delay_cnt_reg == 16'h0001) begin
						queue_pointer_reg <= pend_ptr_reg;
						state_reg <= PTS_EXEC;
					end
				end
				default: begin
				end
			endcase
			if (finish) begin
				// extra delay clocks on top of the executing one
				if (step_delay_timer_reg && limit_reg[`PTS_LIM_DELAY] != 16'h0000) begin
					state_reg <= PTS_DELAY;
					delay_cnt_reg <= limit_reg[`PTS_LIM_DELAY];
					pend_ptr_reg <= finish_ptr;
				end else begin
					queue_pointer_reg <= finish_ptr;
					state_reg <= PTS_EXEC;
				end
			end
		end
	end

	// ----------------------------------------
	// software writable registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (wr_go && !locked && addr_reg[7:6] == `PTS_QUEUE_TAG) begin
			queue_reg[addr_reg[5:2]] <= hwdata[15:0];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int k = 0; k < `PTS_LIM_COUNT; k++) begin
				limit_reg[k] <= 16'h0000;
			end
			hold_value_reg <= 16'h0000;
			adjust_value_reg <= 16'h0000;
			broadcast_enable_reg <= 32'h0000_0000;
		end else begin
			if (lim_we) begin
				limit_reg[lim_idx] <= lim_val;
			end
			if (wr_go && !locked) begin
				if (addr_reg >= `PTS_OFF_LIM0 && addr_reg <= `PTS_OFF_LIM5 && addr_reg[1:0] == 2'h0) begin
					limit_reg[3'(addr_reg[5:2] - 4'h4)] <= hwdata[15:0];
				end else if (addr_reg == `PTS_OFF_HOLD) begin
					hold_value_reg <= hwdata[15:0];
				end else if (addr_reg == `PTS_OFF_ADJ) begin
					adjust_value_reg <= hwdata[15:0];
				end else if (addr_reg == `PTS_OFF_BTE) begin
					broadcast_enable_reg <= hwdata;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			module_enable_bit_reg <= 1'b0;
			run_bit_reg <= 1'b0;
			software_trigger_bit_reg <= 1'b0;
			swt_prev_reg <= 1'b0;
			step_delay_timer_reg <= 1'b0;
		end else begin
			swt_prev_reg <= software_trigger_bit_reg;
			if (wr_go && addr_reg == `PTS_OFF_CTRL) begin
				module_enable_bit_reg <= hwdata[`PTS_CTRL_EN];
				run_bit_reg <= hwdata[`PTS_CTRL_RUN];
				software_trigger_bit_reg <= hwdata[`PTS_CTRL_SWT];
				step_delay_timer_reg <= hwdata[`PTS_CTRL_SDEN];
			end
			if (exec && cmd == `PTS_CMD_CTRL && opt == `PTS_OPT_SD_OFF) begin
				step_delay_timer_reg <= 1'b0;
			end else if (exec && cmd == `PTS_CMD_CTRL && opt == `PTS_OPT_SD_ON) begin
				step_delay_timer_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// loop counters
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			loop_count_a_reg <= 16'h0000;
			loop_count_b_reg <= 16'h0000;
		end else begin
			if (wr_go && !locked && addr_reg == `PTS_OFF_CNTA) begin
				loop_count_a_reg <= hwdata[15:0];
			end else if (exec && cmd[3:1] == `PTS_GRP_LOOPA && loop_count_a_reg != limit_reg[`PTS_LIM_LOOP_A]) begin
				loop_count_a_reg <= loop_count_a_reg + 16'h0001;
			end
			if (wr_go && !locked && addr_reg == `PTS_OFF_CNTB) begin
				loop_count_b_reg <= hwdata[15:0];
			end else if (exec && cmd[3:1] == `PTS_GRP_LOOPB && loop_count_b_reg != limit_reg[`PTS_LIM_LOOP_B]) begin
				loop_count_b_reg <= loop_count_b_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// ADC channel select
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			adc_channel_select_reg <= 16'h0000;
		end else if (exec && cmd[3:1] == `PTS_GRP_STRB) begin
			adc_channel_select_reg[4:0] <= five;
		end else if (exec && cmd == `PTS_CMD_CTRL && opt == `PTS_OPT_CNTA_ADC) begin
			adc_channel_select_reg <= loop_count_a_reg;
		end else if (exec && cmd == `PTS_CMD_CTRL && opt == `PTS_OPT_CNTB_ADC) begin
			adc_channel_select_reg <= loop_count_b_reg;
		end else if (exec && cmd == `PTS_CMD_CTRL && opt == `PTS_OPT_LIT_ADC) begin
			adc_channel_select_reg <= limit_reg[`PTS_LIM_LITERAL];
		end else if (wr_go && addr_reg == `PTS_OFF_ADCSEL) begin
			adc_channel_select_reg <= hwdata[15:0];
		end
	end

	// ----------------------------------------
	// trigger and interrupt pulses
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			trigger_line <= 32'h0000_0000;
			seq_irq <= 4'h0;
		end else begin
			trigger_line <= 32'h0000_0000;
			seq_irq <= 4'h0;
			// line numbers fixed by the consuming peripherals
			if (exec && cmd[3:1] == `PTS_GRP_TRIG) begin
				trigger_line[five] <= 1'b1;
			end else if (exec && cmd == `PTS_CMD_CTRL && opt == `PTS_OPT_BCAST) begin
				trigger_line <= broadcast_enable_reg;
			end
			// other codes fall through untouched
			if (exec && cmd == `PTS_CMD_IRQ && opt <= `PTS_IRQ_LAST) begin
				seq_irq[opt[1:0]] <= 1'b1;
			end
		end
	end

endmodule : pts_sequencer
`default_nettype wire

// ==== design/pts_defines.svh ====
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PTS_OFF_CTRL 8'h00
`define PTS_OFF_BTE 8'h04
`define PTS_OFF_HOLD 8'h08
`define PTS_OFF_ADJ 8'h0C
`define PTS_OFF_LIM0 8'h10
`define PTS_OFF_LIM5 8'h24
`define PTS_OFF_QPTR 8'h28
`define PTS_OFF_ADCSEL 8'h2C
`define PTS_OFF_CNTA 8'h30
`define PTS_OFF_CNTB 8'h34
`define PTS_QUEUE_TAG 2'h1

// ----------------------------------------
// limit bank indices
// ----------------------------------------
`define PTS_LIM_LOOP_A 3'h0
`define PTS_LIM_LOOP_B 3'h1
`define PTS_LIM_TMR_A 3'h2
`define PTS_LIM_TMR_B 3'h3
`define PTS_LIM_DELAY 3'h4
`define PTS_LIM_LITERAL 3'h5
`define PTS_LIM_COUNT 6

// ----------------------------------------
// control register bits
// ----------------------------------------
`define PTS_CTRL_EN 0
`define PTS_CTRL_RUN 1
`define PTS_CTRL_SWT 2
`define PTS_CTRL_SDEN 3

// ----------------------------------------
// step command codes (upper nibble)
// ----------------------------------------
`define PTS_CMD_CTRL 4'h0
`define PTS_CMD_ADD 4'h1
`define PTS_CMD_RISE 4'h4
`define PTS_CMD_FALL 4'h5
`define PTS_CMD_IRQ 4'h7
`define PTS_GRP_STRB 3'h1
`define PTS_GRP_TRIG 3'h4
`define PTS_GRP_JMP 3'h5
`define PTS_GRP_LOOPA 3'h6
`define PTS_GRP_LOOPB 3'h7

// ----------------------------------------
// control step options
// ----------------------------------------
`define PTS_OPT_SD_OFF 4'h2
`define PTS_OPT_SD_ON 4'h6
`define PTS_OPT_TMR_A 4'h8
`define PTS_OPT_TMR_B 4'h9
`define PTS_OPT_SWT 4'hB
`define PTS_OPT_CNTA_ADC 4'hC
`define PTS_OPT_CNTB_ADC 4'hD
`define PTS_OPT_LIT_ADC 4'hE
`define PTS_OPT_BCAST 4'hF
`define PTS_IRQ_LAST 4'h3

`endif

// ==== design/pts_pkg.sv ====
package pts_pkg;

	typedef enum logic [3:0] {
		PTS_IDLE = 4'b0001,
		PTS_EXEC = 4'b0010,
		PTS_WAIT = 4'b0100,
		PTS_DELAY = 4'b1000
	} pts_state_t;

	typedef enum logic [1:0] {
		PTS_W_RISE = 2'h0,
		PTS_W_FALL = 2'h1,
		PTS_W_TIMER = 2'h2,
		PTS_W_SWT = 2'h3
	} pts_wait_t;

endpackage : pts_pkg

// ==== bench/pts_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module pts_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [31:0] trigger_line,
	input wire logic [3:0] seq_irq,
	input wire logic [15:0] adc_channel_select_reg
);
	logic dp_wr_reg, run_reg;
	logic [7:0] dp_addr_reg;
	wire logic take = hsel && htrans[1] && hready;
	wire logic adc_wr = dp_wr_reg && hready && dp_addr_reg == 8'h2C;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else if (hready) begin
			dp_wr_reg <= take && hwrite;
			dp_addr_reg <= haddr[7:0];
		end
	end
	// enable and run as last written by software
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) run_reg <= 1'b0;
		else if (dp_wr_reg && hready && dp_addr_reg == 8'h00) run_reg <= hwdata[0] && hwdata[1];
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence rd_stall;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence halted;
		!run_reg [*3];
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	chk_read_stall: assert property (take && !hwrite |=> rd_stall) else $error("read wait state wrong");
	chk_write_fast: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	chk_rdata_hold: assert property (hreadyout && !(take && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
	chk_irq_single: assert property ($onehot0(seq_irq)) else $error("two interrupts at once");
	chk_reset_quiet: assert property ($fell(reset) |-> trigger_line == 32'h0 && seq_irq == 4'h0
		&& adc_channel_select_reg == 16'h0) else $error("outputs busy after reset");
	chk_stop_quiet: assert property (halted |-> trigger_line == 32'h0 && seq_irq == 4'h0)
		else $error("pulse while stopped");
	chk_adc_hold: assert property (halted ##0 !$past(adc_wr) |-> $stable(adc_channel_select_reg))
		else $error("channel select moved while stopped");
endmodule : pts_checker

bind pts_sequencer pts_checker u_chk (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .trigger_line(trigger_line), .seq_irq(seq_irq),
	.adc_channel_select_reg(adc_channel_select_reg));
`default_nettype wire

// ==== bench/pts_periph_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// peripheral event sources
// ----------------------------------------
module pts_periph_model (
	input wire logic ref_clk,
	input wire logic [15:0] ev_mask,
	input wire logic [15:0] ev_lvl,
	output logic [15:0] trig_in
);
	int seed = 15022;
	logic [15:0] noise_reg = 16'h0000;
	// unselected lines toggle at random, so a wrong select completes early
	always @(posedge ref_clk) noise_reg <= 16'($random(seed));
	// held lines stay quiet while the other lines toggle
	always_comb begin
		trig_in = (noise_reg & ~ev_mask) | (ev_lvl & ev_mask);
	end
endmodule : pts_periph_model
`default_nettype wire

// ==== bench/peripheral_trigger_sequencer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pts_defines.svh"
// ----------------------------------------
// bench
// ----------------------------------------
module peripheral_trigger_sequencer_tb;
	logic ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic rdy_s = 1'b1, rd_dp = 1'b0, rd_chk = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_s, q, bte, trigger_line;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] seq_irq;
	// event lines 5 and 10 held, line 10 starts high
	logic [15:0] ev_mask = 16'h0420, ev_lvl = 16'h0400;
	logic [15:0] trig_in, adc, hold, adj, lit, ta, tb, sd;
	logic [7:0] prog [32];
	logic [35:0] notes [$];
	wire logic hready, hresp;
	int ts [$];
	wire logic [31:0] rd_s_w;
	int error_cnt = 0, comparisons = 0, cyc = 0, la, seed = 15022;
	pts_sequencer DUT (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
		.hrdata(rd_s_w), .trig_in(trig_in), .trigger_line(trigger_line), .seq_irq(seq_irq),
		.adc_channel_select_reg(adc));
	pts_periph_model u_periph (.ref_clk(ref_clk), .ev_mask(ev_mask), .ev_lvl(ev_lvl), .trig_in(trig_in));
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic take(input logic [35:0] seen);
		logic [35:0] exp;
		exp = notes.size() ? notes.pop_front() : 36'hFFFFFFFFF;
		check(seen, exp);
	endtask : take
	// one single transfer; read data left in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge ref_clk); while (rdy_s !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (rdy_s !== 1'b1);
		q = rd_s;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		notes.push_back({4'h0, e});
		rd_chk = 1'b1;
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic poll();
		rd_chk = 1'b0;
		do bus(1'b0, `PTS_OFF_CTRL, 32'h0); while (q[7:4] !== 4'h4);
	endtask : poll
	task automatic upto(input int n);
		while (ts.size() < n) @(posedge ref_clk);
	endtask : upto
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (rdy_s) rd_dp <= hsel && htrans[1] && !hwrite;
	end
	always @(negedge ref_clk) begin
		rdy_s = hready;
		rd_s = rd_s_w;
		if (rd_dp && hready && rd_chk) take({4'h0, rd_s_w});
		if (trigger_line !== 32'h0) begin
			take({4'h1, trigger_line});
			ts.push_back(cyc);
		end
		if (seq_irq !== 4'h0) take({4'h2, 28'h0, seq_irq});
	end
	initial begin
		repeat (50000) @(posedge ref_clk);
		error_cnt++;
		conclude();
	end
	initial begin
		prog = '{8'h18, 8'h10, 8'h9F, 8'hC2, 8'h70, 8'h71, 8'h72, 8'h73, 8'h0C, 8'h45, 8'h3F, 8'h5A, 8'h0F, 8'h08,
			8'h80, 8'h09, 8'h81, 8'h0E, 8'h0B, 8'hB6, 8'h87, 8'h87, 8'h06, 8'h82, 8'h83, 8'h02, 8'h84, 8'h60,
			8'h86, 8'hFC, 8'h0D, 8'hBF};
		hold = 16'h1 + 16'($random(seed) & 7);
		adj = 16'($random(seed) & 3);
		ta = 16'($random(seed) & 15);
		tb = 16'($random(seed) & 15);
		sd = 16'h1 + 16'($random(seed) & 7);
		lit = 16'($random(seed));
		bte = $random(seed) | 32'h1;
		la = hold + adj;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`PTS_OFF_LIM0, 32'h0);
		wr(8'h38, 32'hFFFF);
		rd(8'h38, 32'h0);
		for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), {16'h0, prog[2 * i + 1], prog[2 * i]});
		wr(`PTS_OFF_HOLD, {16'h0, hold});
		wr(`PTS_OFF_ADJ, {16'h0, adj});
		wr(8'h14, 32'h1);
		wr(8'h18, {16'h0, ta});
		wr(8'h1C, {16'h0, tb});
		wr(8'h20, {16'h0, sd});
		wr(`PTS_OFF_LIM5, {16'h0, lit});
		wr(`PTS_OFF_BTE, bte);
		wr(`PTS_OFF_CNTA, 32'h0);
		wr(`PTS_OFF_CNTB, 32'h0);
		wr(`PTS_OFF_QPTR, 32'h0);
		for (int i = 0; i <= la; i++) notes.push_back({4'h1, 32'h80000000});
		for (int i = 0; i < 4; i++) notes.push_back({4'h2, 32'h1 << i});
		wr(`PTS_OFF_CTRL, 32'h3);
		poll();
		rd(`PTS_OFF_ADCSEL, 32'(la));
		@(posedge ref_clk);
		ev_lvl <= 16'h0420;
		repeat (8) @(posedge ref_clk);
		poll();
		rd(`PTS_OFF_ADCSEL, 32'h1F);
		notes.push_back({4'h1, bte});
		notes.push_back({4'h1, 32'h1});
		notes.push_back({4'h1, 32'h2});
		@(posedge ref_clk);
		ev_lvl <= 16'h0020;
		upto(la + 4);
		poll();
		rd(`PTS_OFF_ADCSEL, {16'h0, lit});
		check({20'h0, adc}, {20'h0, lit});
		wr(8'h14, 32'h5);
		rd(8'h14, 32'h1);
		for (int i = 2; i < 5; i++) notes.push_back({4'h1, 32'h1 << i});
		notes.push_back({4'h1, 32'h40});
		notes.push_back({4'h1, 32'h40});
		wr(`PTS_OFF_CTRL, 32'h3);
		wr(`PTS_OFF_CTRL, 32'h7);
		upto(la + 9);
		check(36'(ts[la + 3] - 2 * ts[la + 2] + ts[la + 1]), 36'(int'(tb) - int'(ta)));
		check(36'(ts[la + 5] - ts[la + 4]), 36'(sd + 16'h1));
		check(36'(ts[la + 7] - ts[la + 6]), 36'h2);
		check(36'(ts[la + 8] - ts[la + 7]), 36'h2);
		check(36'(ts[1] - ts[0]), 36'h2);
		rd(`PTS_OFF_ADCSEL, 32'h1);
		check({20'h0, adc}, 36'h1);
		rd(`PTS_OFF_QPTR, 32'h1F);
		wr(`PTS_OFF_CTRL, 32'h0);
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		rd(8'h40, {16'h0, prog[1], prog[0]});
		rd(`PTS_OFF_QPTR, 32'h0);
		rd(`PTS_OFF_LIM0, 32'h0);
		conclude();
	end
endmodule : peripheral_trigger_sequencer_tb
`default_nettype wire
